// *** rtl/gpio_ab_pkg.sv ***
// shared constants and types for the dual general-purpose port block
package gpio_ab_pkg;
   localparam int unsigned PORT_A_WIDTH = 6;
   localparam int unsigned PORT_B_WIDTH = 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN_DATA_A = 8'h05;
   localparam logic [7:0] IDX_PIN_DATA_B = 8'h06;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h0B;
   localparam logic [7:0] IDX_OPTION = 8'h81;
   localparam logic [7:0] IDX_DIR_A = 8'h85;
   localparam logic [7:0] IDX_DIR_B = 8'h86;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h8B;
   localparam logic [7:0] IDX_LOW_VOLT_PROG = 8'h90;
   localparam logic [7:0] IDX_COMPARATOR = 8'h9C;
   localparam logic [7:0] IDX_ADC_PIN = 8'h9F;

   // reset values
   localparam logic [7:0] RST_OPTION = 8'hFF;
   localparam logic [7:0] RST_DIR_B = 8'hFF;
   localparam logic [5:0] RST_DIR_A = 6'h3F;
   localparam logic [5:0] RST_LATCH_A = 6'h00;
   localparam logic [7:0] RST_LATCH_B = 8'h00;
   localparam logic [5:0] RST_ADC_PIN = 6'h2F;
   localparam logic [7:0] RST_COMPARATOR = 8'h07;
   localparam logic [0:0] RST_LOW_VOLT_PROG = 1'b1;
   localparam logic [1:0] RST_IRQ = 2'b00;

   // field positions
   localparam int unsigned IRQ_EXT = 0;
   localparam int unsigned IRQ_CHANGE = 1;
   localparam int unsigned CMP_C1_OE = 4;
   localparam int unsigned CMP_C2_OE = 5;
   localparam logic [2:0] CMP_MODE_OFF = 3'h7;
   localparam logic [7:0] CHANGE_MASK = 8'hF0;
   localparam logic [5:0] OPEN_DRAIN_MASK = 6'h10;

   typedef struct packed {
      logic pullup_disable_n;
      logic ext_irq_edge_select;
      logic timer_zero_clock_source;
      logic timer_zero_edge_select;
      logic prescaler_assign;
      logic prescaler_select_hi;
      logic prescaler_select_mid;
      logic prescaler_select_lo;
   } option_t;

   typedef struct packed {
      logic [5:0] latch_a;
      logic [5:0] dir_a;
      logic [7:0] latch_b;
      logic [7:0] dir_b;
      option_t opt;
      logic [5:0] adc_pin;
      logic [7:0] comparator;
      logic [0:0] low_voltage_programming;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic [7:0] prev_b;
      logic dp_valid;
      logic dp_write;
      logic dp_hit;
      logic dp_lane0;
      logic [7:0] dp_idx;
      logic [7:0] rdata;
   } state_t;
endpackage

// *** rtl/dual_gpio_port_ab.sv ***
// two general-purpose ports with pin sharing, option register and pin interrupts
`timescale 1ns/10ps
`default_nettype none
module dual_gpio_port_ab
   import gpio_ab_pkg::*;
(
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [5:0] pin_a_in,
   output logic [5:0] pin_a_out,
   output logic [5:0] pin_a_oe_out,
   input wire logic [5:0] alt_enable_a_in,
   input wire logic [5:0] alt_data_a_in,
   input wire logic [5:0] alt_oe_a_in,
   input wire logic [1:0] comparator_out_in,
   output logic [5:0] analog_select_a_out,
   output logic timer_zero_ext_clock_in_out,
   input wire logic [7:0] pin_b_in,
   output logic [7:0] pin_b_out,
   output logic [7:0] pin_b_oe_out,
   output logic [7:0] pullup_b_out,
   output logic [7:0] schmitt_b_out,
   input wire logic prog_mode_in,
   input wire logic prog_data_in,
   input wire logic prog_data_oe_in,
   output logic serial_prog_clock_out,
   output logic serial_prog_data_out,
   output logic low_volt_prog_enable_pin_out,
   output option_t option_out,
   output logic irq_out
);

   localparam state_t STATE_RST = '{
      latch_a: RST_LATCH_A,
      dir_a: RST_DIR_A,
      latch_b: RST_LATCH_B,
      dir_b: RST_DIR_B,
      opt: option_t'(RST_OPTION),
      adc_pin: RST_ADC_PIN,
      comparator: RST_COMPARATOR,
      low_voltage_programming: RST_LOW_VOLT_PROG,
      irq_status: RST_IRQ,
      irq_mask: RST_IRQ,
      prev_b: 8'h00,
      dp_valid: 1'b0,
      dp_write: 1'b0,
      dp_hit: 1'b0,
      dp_lane0: 1'b0,
      dp_idx: 8'h00,
      rdata: 8'h00
   };

   state_t q;
   state_t d;
   logic cmp_on;
   logic [5:0] analog_a;
   logic [5:0] cmp_en_a;
   logic [5:0] val_a;
   logic [5:0] gp_oe_a;
   logic [5:0] gp_out_a;
   logic [7:0] rd_a;
   logic [7:0] rd_b;
   logic [7:0] blocked_b;
   logic [7:0] prog_drive_b;
   logic [7:0] chg_b;
   logic ext_edge;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic take;
   logic wr;
   logic [7:0] wm;
   logic [7:0] wv;
   logic [7:0] rv;

   assign cmp_on = q.comparator[2:0] != CMP_MODE_OFF;
   assign analog_a = {q.adc_pin[5], 1'b0, q.adc_pin[3:0] | {4{cmp_on}}};
   assign analog_select_a_out = analog_a;
   assign cmp_en_a = {q.comparator[CMP_C2_OE], q.comparator[CMP_C1_OE], 4'h0} & {6{cmp_on}};

   assign rd_a = {2'b00, pin_a_in & ~analog_a};

   assign val_a = (cmp_en_a & {comparator_out_in, 4'h0}) | (~cmp_en_a & q.latch_a);
   assign gp_oe_a = ~q.dir_a & ~(OPEN_DRAIN_MASK & val_a);
   assign gp_out_a = val_a & ~OPEN_DRAIN_MASK;

   assign pin_a_oe_out = (alt_enable_a_in & alt_oe_a_in) | (~alt_enable_a_in & gp_oe_a);
   assign pin_a_out = (alt_enable_a_in & alt_data_a_in) | (~alt_enable_a_in & gp_out_a);

   assign timer_zero_ext_clock_in_out = pin_a_in[4];

   assign blocked_b = {prog_mode_in, prog_mode_in, 2'b00, q.low_voltage_programming[0], 3'b000};
   assign prog_drive_b = {prog_mode_in, 7'h00};
   assign pin_b_oe_out = (~blocked_b & ~q.dir_b) | (prog_drive_b & {prog_data_oe_in, 7'h00});
   assign pin_b_out = (~blocked_b & q.latch_b) | (prog_drive_b & {prog_data_in, 7'h00});
   assign rd_b = pin_b_in & ~{4'h0, q.low_voltage_programming[0], 3'b000};

   assign serial_prog_clock_out = prog_mode_in & pin_b_in[6];
   assign serial_prog_data_out = prog_mode_in & pin_b_in[7];
   assign low_volt_prog_enable_pin_out = q.low_voltage_programming[0] & pin_b_in[3];

   assign pullup_b_out = {8{~q.opt.pullup_disable_n}} & q.dir_b;

   assign schmitt_b_out = {prog_mode_in, prog_mode_in, 5'h00, q.irq_mask[IRQ_EXT]};

   // change on upper inputs
   // output pins are left out so own drive changes raise nothing
   assign chg_b = (pin_b_in ^ q.prev_b) & q.dir_b & CHANGE_MASK;
   assign ext_edge = q.opt.ext_irq_edge_select ?
                     (pin_b_in[0] & ~q.prev_b[0]) : (~pin_b_in[0] & q.prev_b[0]);
   assign irq_set = {|chg_b, ext_edge};

   assign option_out = q.opt;
   assign irq_out = |(q.irq_status & q.irq_mask);
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = {24'h00_0000, q.rdata};

   assign take = hsel_in & htrans_in[1] & hready_in;
   assign wr = q.dp_valid & q.dp_write & q.dp_hit;
   // a write that misses byte lane zero still rewrites the latch from the pins
   assign wm = q.dp_lane0 ? 8'hFF : 8'h00;
   assign wv = hwdata_in[7:0] & wm;

   always_comb begin
      d = q;
      irq_clr = 2'b00;
      rv = 8'h00;
      d.prev_b = pin_b_in;
      if (wr) begin
         case (q.dp_idx)
            IDX_PIN_DATA_A: begin
               d.latch_a = (rd_a[5:0] & ~wm[5:0]) | wv[5:0];
            end
            IDX_PIN_DATA_B: begin
               d.latch_b = (rd_b & ~wm) | wv;
            end
            IDX_DIR_A: begin
               d.dir_a = (q.dir_a & ~wm[5:0]) | wv[5:0];
            end
            IDX_DIR_B: begin
               d.dir_b = (q.dir_b & ~wm) | wv;
            end
            IDX_OPTION: begin
               d.opt = option_t'((q.opt & ~wm) | wv);
            end
            IDX_ADC_PIN: begin
               d.adc_pin = (q.adc_pin & ~wm[5:0]) | wv[5:0];
            end
            IDX_COMPARATOR: begin
               d.comparator = (q.comparator & ~wm) | wv;
            end
            IDX_LOW_VOLT_PROG: begin
               d.low_voltage_programming = (q.low_voltage_programming & ~wm[0]) | wv[0];
            end
            IDX_IRQ_STATUS: begin
               irq_clr = wv[1:0];
            end
            IDX_IRQ_MASK: begin
               d.irq_mask = (q.irq_mask & ~wm[1:0]) | wv[1:0];
            end
            default: begin
            end
         endcase
      end
      // set wins over a same-cycle clear
      d.irq_status = (q.irq_status & ~irq_clr) | irq_set;
      if (take) begin
         d.dp_valid = 1'b1;
         d.dp_write = hwrite_in;
         d.dp_hit = haddr_in[31:10] == 22'h00_0000;
         d.dp_lane0 = haddr_in[1:0] == 2'b00;
         d.dp_idx = haddr_in[9:2];
         // reads see the value just written by the previous data phase
         case (haddr_in[9:2])
            IDX_PIN_DATA_A: rv = rd_a;
            IDX_PIN_DATA_B: rv = rd_b;
            IDX_DIR_A: rv = {2'b00, d.dir_a};
            IDX_DIR_B: rv = d.dir_b;
            IDX_OPTION: rv = d.opt;
            IDX_ADC_PIN: rv = {2'b00, d.adc_pin};
            IDX_COMPARATOR: rv = d.comparator;
            IDX_LOW_VOLT_PROG: rv = {7'h00, d.low_voltage_programming};
            IDX_IRQ_STATUS: rv = {6'h00, d.irq_status};
            IDX_IRQ_MASK: rv = {6'h00, d.irq_mask};
            default: rv = 8'h00;
         endcase
         if (!hwrite_in) begin
            d.rdata = d.dp_hit ? rv : 8'h00;
         end
      end else begin
         d.dp_valid = 1'b0;
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q <= STATE_RST;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);

   logic [5:0] wr_low_a;
   logic [5:0] drv_mask_a;
   assign wr_low_a = hwdata_in[5:0];
   assign drv_mask_a = ~q.dir_a & ~alt_enable_a_in & ~cmp_en_a & ~OPEN_DRAIN_MASK;

   sequence s_write(logic [7:0] idx);
      q.dp_valid && q.dp_write && q.dp_hit && q.dp_lane0 && q.dp_idx == idx;
   endsequence

   sequence s_read(logic [7:0] idx);
      take && !hwrite_in && haddr_in == {22'h00_0000, idx, 2'b00};
   endsequence

   a_dir_input_hiz: assert property (
      (pin_a_oe_out & q.dir_a & ~alt_enable_a_in) == 6'h00)
      else $error("input pin of port a is driven");

   a_latch_drives_pin: assert property (
      (pin_a_oe_out & drv_mask_a) == drv_mask_a &&
      (pin_a_out & drv_mask_a) == (q.latch_a & drv_mask_a))
      else $error("output pin of port a not driven from latch");

   a_rmw_latch_a: assert property (
      s_write(IDX_PIN_DATA_A) |=> q.latch_a == $past(wr_low_a))
      else $error("port a latch did not take written value");

   a_read_pins_b: assert property (
      s_read(IDX_PIN_DATA_B) |=> hrdata_out[7:0] == $past(rd_b))
      else $error("port b read does not show pins");

   a_analog_reads_zero: assert property (
      s_read(IDX_PIN_DATA_A) |=> (hrdata_out[7:0] & {2'b11, $past(analog_a)}) == 8'h00)
      else $error("analog or missing port a bit reads one");

   a_open_drain_four: assert property (
      !alt_enable_a_in[4] |-> !pin_a_out[4] && (pin_a_oe_out[4] == (!q.dir_a[4] && !val_a[4])))
      else $error("pin four does not behave as open drain");

   a_alt_takeover: assert property (
      (pin_a_oe_out & alt_enable_a_in) == (alt_oe_a_in & alt_enable_a_in))
      else $error("peripheral does not own its pin");

   a_prog_blocks_pin: assert property (
      q.low_voltage_programming[0] |-> !pin_b_oe_out[3] && !rd_b[3])
      else $error("pin three acts as i/o under programming enable");

   a_prog_takeover: assert property (
      prog_mode_in |-> !pin_b_oe_out[6] && pin_b_oe_out[7] == prog_data_oe_in)
      else $error("programming pins still driven by latch");

   a_change_sets_flag: assert property (
      (chg_b != 8'h00) |=> q.irq_status[IRQ_CHANGE])
      else $error("change on port b did not set flag");

   a_ext_edge_flag: assert property (
      q.opt.ext_irq_edge_select && $rose(pin_b_in[0]) && q.irq_mask[IRQ_EXT]
      |=> q.irq_status[IRQ_EXT] && irq_out)
      else $error("rising edge on pin zero did not interrupt");

   a_pullup_off_write: assert property (
      s_write(IDX_OPTION) && hwdata_in[7] |=> pullup_b_out == 8'h00)
      else $error("pull-ups on with disable bit set");

   a_reset_values: assert property (
      $rose(nrst_in) |-> q.dir_b == RST_DIR_B && q.opt == option_t'(RST_OPTION))
      else $error("direction or option not all ones after reset");

   sequence s_write_miss(logic [7:0] idx);
      q.dp_valid && q.dp_write && q.dp_hit && !q.dp_lane0 && q.dp_idx == idx;
   endsequence

   a_rmw_lane_miss: assert property (
      s_write_miss(IDX_PIN_DATA_A) |=> q.latch_a == $past(rd_a[5:0]))
      else $error("port a latch did not keep the sampled pins");

   a_port_a_width: assert property (
      s_read(IDX_PIN_DATA_A) |=> hrdata_out[31:6] == 26'h000_0000)
      else $error("port a read shows bits above its six pins");

   a_analog_select: assert property (
      !analog_select_a_out[4] &&
      (q.comparator[2:0] == CMP_MODE_OFF || analog_select_a_out[3:0] == 4'hF))
      else $error("analog selection of port a pins is wrong");

   a_analog_keeps_dir: assert property (
      analog_select_a_out[0] && !alt_enable_a_in[0] |-> pin_a_oe_out[0] == !q.dir_a[0])
      else $error("analog use cut a port a driver");

   a_pullup_inputs_only: assert property (
      (pullup_b_out & ~q.dir_b) == 8'h00)
      else $error("weak pull-up on a port b output");

   a_pullup_enabled: assert property (
      !q.opt.pullup_disable_n |-> pullup_b_out == q.dir_b)
      else $error("pull-ups missing on port b inputs");

   a_change_clear: assert property (
      s_write(IDX_IRQ_STATUS) && hwdata_in[IRQ_CHANGE] && chg_b == 8'h00
      |=> !q.irq_status[IRQ_CHANGE])
      else $error("change flag not cleared by writing one");

   a_ext_schmitt: assert property (
      schmitt_b_out[0] == q.irq_mask[IRQ_EXT])
      else $error("pin zero input buffer wrong for interrupt use");

   a_prog_schmitt: assert property (
      prog_mode_in |-> schmitt_b_out[7:6] == 2'b11)
      else $error("programming pins lack schmitt inputs");

   a_prog_sense_off: assert property (
      !q.low_voltage_programming[0] |-> !low_volt_prog_enable_pin_out)
      else $error("programming enable sensed with low-voltage mode off");

   a_irq_level: assert property (
      (q.irq_status & q.irq_mask) != 2'b00 |-> irq_out)
      else $error("pending unmasked event without interrupt");

endmodule
`default_nettype wire

// *** verif/gpio_board_model.sv ***
// board-side model of the port pins
`timescale 1ns/10ps
`default_nettype none
module gpio_board_model (
   input wire logic clock_in,
   input wire logic [13:0] out_in,
   input wire logic [13:0] oe_in,
   input wire logic [13:0] pull_in,
   input wire logic [13:0] ext_in,
   input wire logic [13:0] ext_en_in,
   output logic [13:0] level_out
);
   logic [13:0] flt_q = 14'h2AAA;
   // an undriven line wanders so a stale level never reads back as valid
   always_ff @(posedge clock_in) begin
      flt_q <= ~flt_q;
   end
   // weak pull-up holds an undriven input high
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         if (oe_in[i]) level_out[i] = out_in[i];
         else if (ext_en_in[i]) level_out[i] = ext_in[i];
         else if (pull_in[i]) level_out[i] = 1'b1;
         else level_out[i] = flt_q[i];
      end
   end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the dual port block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import gpio_ab_pkg::*;
   logic clk = 0, nrst = 0, hsel = 0, hwrite = 0, pmode = 0, pdat = 0, pdoe = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = '0, cmp = '0;
   logic hrdy, hresp, irq, t0ck, spc, spd, lvpo;
   logic [5:0] pa_in, pa_out, pa_oe, asel, l, d, aen = '0, adat = '0, aoe = '0;
   logic [7:0] pb_in, pb_out, pb_oe, pull, schm, d8;
   logic [13:0] ext = '0, exen = '1, lvl;
   logic [11:0] x;
   option_t opt;
   int errors = 0, checks_done = 0, cyc = 0;
   assign pa_in = lvl[5:0];
   assign pb_in = lvl[13:6];
   dual_gpio_port_ab i_dut (.clock_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .pin_a_in(pa_in), .pin_a_out(pa_out), .pin_a_oe_out(pa_oe), .alt_enable_a_in(aen),
      .alt_data_a_in(adat), .alt_oe_a_in(aoe), .comparator_out_in(cmp),
      .analog_select_a_out(asel), .timer_zero_ext_clock_in_out(t0ck), .pin_b_in(pb_in),
      .pin_b_out(pb_out), .pin_b_oe_out(pb_oe), .pullup_b_out(pull), .schmitt_b_out(schm),
      .prog_mode_in(pmode), .prog_data_in(pdat), .prog_data_oe_in(pdoe),
      .serial_prog_clock_out(spc), .serial_prog_data_out(spd),
      .low_volt_prog_enable_pin_out(lvpo), .option_out(opt), .irq_out(irq));
   gpio_board_model i_board (.clock_in(clk), .out_in({pb_out, pa_out}),
      .oe_in({pb_oe, pa_oe}), .pull_in({pull, 6'h00}), .ext_in(ext), .ext_en_in(exen),
      .level_out(lvl));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic results;
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // address phase held until ready, then data phase until ready again
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      bus(1'b1, {22'h0, i, 2'b00}, v);
      // the register only changes at the closing edge, so let it settle before compares
      @(posedge clk);
   endtask
   task automatic rdr(input logic [7:0] i);
      bus(1'b0, {22'h0, i, 2'b00}, 8'h00);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // pin 4 only pulls low; a peripheral owning a pin overrides the port
   function automatic logic [11:0] exp_a(input logic [5:0] lt, input logic [5:0] dr,
      input logic [5:0] e);
      logic [5:0] oe, lv;
      for (int i = 0; i < 6; i++) begin
         oe[i] = aen[i] ? aoe[i] : (~dr[i] & ((i != 4) | ~lt[i]));
         lv[i] = ~oe[i] ? e[i] : (aen[i] ? adat[i] : ((i != 4) & lt[i]));
      end
      return {oe, lv};
   endfunction
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         errors++;
         results();
      end
   end
   initial begin
      void'($urandom(24891));
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rdr(IDX_OPTION);
      chk("opt_rst", rd, {24'h0, RST_OPTION});
      rdr(IDX_DIR_B);
      chk("dirb_rst", rd, {24'h0, RST_DIR_B});
      ext[5:0] <= 6'h3F;
      rdr(IDX_PIN_DATA_A);
      chk("pa_analog", rd, {26'h0, ~RST_ADC_PIN});
      chk("asel_rst", {26'h0, asel}, {26'h0, RST_ADC_PIN});
      chk("pull_rst", {24'h0, pull}, 32'h0);
      rdr(8'h50);
      chk("unmapped", rd, 32'h0);
      chk("hresp", {31'h0, hresp}, 32'h0);
      wr(IDX_ADC_PIN, 8'h00);
      for (int k = 0; k < 24; k++) begin
         l = 6'($urandom);
         d = (k == 0) ? 6'h00 : 6'($urandom);
         aen <= (k > 12) ? 6'($urandom) : 6'h00;
         adat <= 6'($urandom);
         aoe <= 6'($urandom);
         ext[5:0] <= 6'($urandom);
         wr(IDX_PIN_DATA_A, {2'b00, l});
         wr(IDX_DIR_A, {2'b00, d});
         x = exp_a(l, d, ext[5:0]);
         chk("pa_oe", {26'h0, pa_oe}, {26'h0, x[11:6]});
         chk("pa_out", {26'h0, pa_out & x[11:6]}, {26'h0, x[5:0] & x[11:6]});
         rdr(IDX_PIN_DATA_A);
         chk("pa_read", rd, {26'h0, x[5:0]});
         chk("t0ck", {31'h0, t0ck}, {31'h0, x[4]});
      end
      aen <= 6'h00;
      ext[5:0] <= 6'h2D;
      wr(IDX_DIR_A, 8'h3F);
      bus(1'b1, {22'h0, IDX_PIN_DATA_A, 2'b01}, 8'h00);
      wr(IDX_DIR_A, 8'h00);
      chk("rmw", {26'h0, pa_out & 6'h2F}, {26'h0, 6'h2D});
      cmp <= 2'b01;
      wr(IDX_DIR_A, 8'h0F);
      wr(IDX_COMPARATOR, 8'h30);
      chk("asel_cmp", {26'h0, asel}, 32'h0000_000F);
      chk("cmp_oe", {26'h0, pa_oe}, 32'h0000_0020);
      chk("cmp_out", {31'h0, pa_out[5]}, 32'h0);
      exen[13:6] <= 8'h00;
      wr(IDX_OPTION, 8'h7F);
      chk("opt", {24'h0, opt}, 32'h0000_007F);
      rdr(IDX_PIN_DATA_B);
      chk("pb_pull", rd, 32'h0000_00F7);
      chk("prog_sense", {31'h0, lvpo}, 32'h1);
      d8 = 8'($urandom) & 8'hF7;
      wr(IDX_DIR_B, d8);
      chk("pull", {24'h0, pull}, {24'h0, d8});
      chk("pb3_prog", {31'h0, pb_oe[3]}, 32'h0);
      wr(IDX_LOW_VOLT_PROG, 8'h00);
      chk("pb_oe", {24'h0, pb_oe}, {24'h0, ~d8});
      pmode <= 1'b1;
      pdoe <= 1'b1;
      pdat <= 1'b1;
      tick(1);
      chk("prog_oe", {30'h0, pb_oe[7:6]}, 32'h2);
      chk("prog_st", {30'h0, schm[7:6]}, 32'h3);
      chk("prog_clk", {31'h0, spc}, {31'h0, pb_in[6]});
      chk("prog_dat", {31'h0, spd}, 32'h1);
      chk("prog_drv", {31'h0, pb_out[7]}, 32'h1);
      pmode <= 1'b0;
      exen[13:6] <= 8'hFF;
      ext[13:6] <= 8'h00;
      wr(IDX_DIR_B, 8'hFF);
      wr(IDX_OPTION, 8'hFF);
      tick(2);
      wr(IDX_IRQ_STATUS, 8'h03);
      wr(IDX_IRQ_MASK, 8'h03);
      chk("schmitt0", {31'h0, schm[0]}, 32'h1);
      ext[13:6] <= 8'h04;
      tick(3);
      rdr(IDX_IRQ_STATUS);
      chk("no_chg", rd, 32'h0);
      ext[13:6] <= 8'h24;
      tick(3);
      rdr(IDX_IRQ_STATUS);
      chk("chg", rd, 32'h2);
      chk("irq_on", {31'h0, irq}, 32'h1);
      wr(IDX_IRQ_STATUS, 8'h02);
      tick(2);
      chk("irq_off", {31'h0, irq}, 32'h0);
      ext[13:6] <= 8'h25;
      tick(3);
      rdr(IDX_IRQ_STATUS);
      chk("ext_irq", rd, 32'h1);
      wr(IDX_IRQ_MASK, 8'h00);
      tick(2);
      chk("masked", {31'h0, irq}, 32'h0);
      results();
   end
endmodule
`default_nettype wire
